// File: hdl/dram_board_ctrl.sv
// Purpose: dual-port dynamic memory controller with parity and refresh
// Assumes: backplane command pins synchronised here, local port on mclk; mclk 25 MHz
// Notes: array modelled as on-chip words; apb holds config and error register
// Notes: a backplane command dropped before its acknowledge gets none
// Overview of operation
// - decode 24-bit addresses, 16 MB range
// - base on 64K boundary, respond in that one 64K segment only
// - same address map on both ports
// - lockout hides last 64K of megabyte zero
// - parity generated and stored on writes
// - parity recomputed and compared on reads
// - mismatch latches row and byte
// - enabled parity error raises interrupt
// - io read returns latched row and low byte lane flag
// - io address 8/16 bit, 32 places
// - parity disable suppresses latch and interrupt
// - read acknowledge at 105 or 225 ns
// - write acknowledge at 50 ns
// - access within 225, cycle within 300
// - internal refresh every 14 us
// - refresh occupies array at most 350 ns
// - external refresh requests replace timer
// - 8/16 bit transfers with byte swap
// - local port zero wait at 5/6 MHz
// - local port one wait at 8/10 MHz
`timescale 1ns/10ps
`default_nettype none
module dram_board_ctrl (
  input wire logic mclk,
  input wire logic arst_n,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // backplane port (asynchronous pins)
  input wire logic [23:0] bp_addr,
  input wire logic [15:0] bp_wdata,
  input wire logic bp_byte_high_en_n,
  input wire logic bp_byte_wide_n,
  input wire logic memory_read_command_n,
  input wire logic memory_write_command_n,
  input wire logic io_read_command_n,
  input wire logic [15:0] io_addr,
  output logic [15:0] bp_rdata,
  output logic [15:0] io_rdata,
  output logic transfer_acknowledge_n,
  output logic io_acknowledge_n,
  output logic parity_irq,
  // local extension port (same clock)
  input wire dram_board_pkg::mem_req_t lbx_req,
  output logic lbx_ack,
  output logic [15:0] lbx_rdata,
  // external refresh request pin
  input wire logic ext_refresh_req
);
  import dram_board_pkg::*;

  logic [15:0] mem_ff [0:(1<<word_addr_w)-1];
  logic [1:0] par_ff [0:(1<<word_addr_w)-1];

  logic [31:0] config_ff;
  logic [31:0] iocfg_ff;
  err_reg_t err_ff;
  logic irq_ff;

  // pin synchronisers: three stages, change counts when 2nd and 3rd agree
  logic [2:0] rd_sync_ff, wr_sync_ff, io_sync_ff, ext_sync_ff;
  logic rd_lvl_ff, wr_lvl_ff, io_lvl_ff, ext_lvl_ff;

  src_t src_ff;
  logic busy_ff;
  logic [cnt_w-1:0] cnt_ff;
  logic cyc_wr_ff;
  logic [word_addr_w-1:0] cyc_word_ff;
  logic [1:0] cyc_lanes_ff;
  logic cyc_swap_ff;
  logic [15:0] cyc_wdata_ff;
  logic bp_ack_ff;
  logic bp_done_ff;
  logic lbx_ack_ff;
  logic [15:0] bp_rdata_ff, lbx_rdata_ff, io_rdata_ff;
  logic io_ack_ff;
  logic ref_pend_ff;
  logic [ref_cnt_w-1:0] ref_timer_ff;
  logic [row_w-1:0] ref_row_ff;

  function automatic logic addr_hit(input logic [addr_w-1:0] a, input logic [7:0] base,
                                    input logic lock);
    logic [7:0] seg;
    logic [7:0] off;
    seg = a[23:16];
    off = seg - base;
    addr_hit = (seg >= base) && (off < cap_segs) && !(lock && seg == lockout_seg);
  endfunction

  function automatic logic [word_addr_w-1:0] word_of(input logic [addr_w-1:0] a,
                                                    input logic [7:0] base);
    logic [7:0] off;
    off = a[23:16] - base;
    word_of = {off[0:0] == 1'b0 ? 1'b0 : 1'b1, a[15:2]} ^ {word_addr_w{1'b0}};
  endfunction

  // decode
  wire [7:0] base_seg = config_ff[cfg_base_lsb +: 8];
  wire lock_on = config_ff[cfg_lockout];
  wire rd_slow = config_ff[cfg_rd_slow];
  wire ext_ref = config_ff[cfg_ext_refresh];
  wire lbx_fast = config_ff[cfg_lbx_fast];
  wire bp_rd = rd_lvl_ff;
  wire bp_wr = wr_lvl_ff;
  wire bp_hit = addr_hit(bp_addr, base_seg, lock_on);
  wire lbx_hit = addr_hit(lbx_req.addr, base_seg, lock_on);
  // withdrawn command: no acknowledge is raised, so the pin never pulses stale
  wire bp_cmd_on = bp_rd | bp_wr;
  wire bp_want = bp_cmd_on & bp_hit & ~bp_done_ff;
  wire lbx_want = lbx_req.req & lbx_hit & ~lbx_ack_ff;
  wire ref_tick = ref_timer_ff == ref_cnt_w'(refresh_period_cyc - 1);
  wire ext_rise = ext_sync_ff[2] & ~ext_lvl_ff;
  wire ref_event = ext_ref ? ext_rise : ref_tick;
  // refresh first so the array never misses its window, then local, then backplane
  wire grant_ref = ~busy_ff & ref_pend_ff;
  wire grant_lbx = ~busy_ff & ~ref_pend_ff & lbx_want;
  wire grant_bp = ~busy_ff & ~ref_pend_ff & ~lbx_want & bp_want;

  // byte steering: odd byte on a byte transfer arrives on the low half
  wire bp_byte = ~bp_byte_wide_n;
  wire bp_odd = bp_addr[0];
  wire [1:0] bp_lanes = bp_byte ? (bp_odd ? 2'b10 : 2'b01) : 2'b11;
  wire [15:0] bp_wswap = (bp_byte & bp_odd) ? {bp_wdata[7:0], bp_wdata[7:0]} : bp_wdata;
  wire [1:0] lbx_lanes = lbx_req.be;

  // cycle parameters captured at the grant edge from the winning port
  wire grant_any = grant_ref | grant_lbx | grant_bp;
  wire nxt_wr = grant_lbx ? lbx_req.wr : bp_wr;
  wire [word_addr_w-1:0] nxt_word = grant_lbx ? word_of(lbx_req.addr, base_seg) :
                                                word_of(bp_addr, base_seg);
  wire [1:0] nxt_lanes = grant_ref ? 2'b00 : (grant_lbx ? lbx_lanes : bp_lanes);
  wire [15:0] nxt_wdata = grant_lbx ? lbx_req.wdata : bp_wswap;

  // counts run from the grant edge; pin commands arrive later through their synchronisers
  wire [cnt_w-1:0] lbx_ack_pt = lbx_fast ? cnt_w'(lbx_one_wait_cyc) : cnt_w'(lbx_zero_wait_cyc);
  wire [cnt_w-1:0] rd_ack_pt = rd_slow ? cnt_w'(rd_slow_cyc) : cnt_w'(rd_fast_cyc);
  wire [cnt_w-1:0] bp_ack_pt = cyc_wr_ff ? cnt_w'(wr_ack_cyc) : rd_ack_pt;
  wire [cnt_w-1:0] ack_point = src_ff == src_lbx ? lbx_ack_pt : bp_ack_pt;
  wire [cnt_w-1:0] end_point = src_ff == src_ref ? cnt_w'(refresh_cyc) : cnt_w'(cycle_cyc);
  wire at_ack = busy_ff && src_ff != src_ref && cnt_ff == ack_point;
  wire at_end = busy_ff && cnt_ff == end_point;

  wire [15:0] rd_word = mem_ff[cyc_word_ff];
  wire [1:0] rd_par = par_ff[cyc_word_ff];
  wire [15:0] old_word = rd_word;
  wire [15:0] merged = {cyc_lanes_ff[1] ? cyc_wdata_ff[15:8] : old_word[15:8],
                        cyc_lanes_ff[0] ? cyc_wdata_ff[7:0] : old_word[7:0]};
  wire [1:0] gen_par;
  wire [1:0] mism;
  wire [1:0] chk_mism;
  parity_word u_wpar (
    .data(merged),
    .stored(2'b00),
    .lanes(2'b11),
    .gen(gen_par),
    .mismatch()
  );
  parity_word u_rpar (
    .data(rd_word),
    .stored(rd_par),
    .lanes(cyc_lanes_ff),
    .gen(),
    .mismatch(mism)
  );
  assign chk_mism = mism;
  wire par_err = at_ack & ~cyc_wr_ff & (|chk_mism) & ~config_ff[cfg_par_dis];
  wire par_irq_set = par_err & config_ff[cfg_par_int_en];
  wire [15:0] rd_swap = (cyc_swap_ff) ? {rd_word[15:8], rd_word[15:8]} : rd_word;

  // io decode of the error register
  wire [7:0] io_win = iocfg_ff[1] ? io_win_hi : io_win_lo;
  wire io_lo_hit = io_addr[7:0] == (io_win | {4'h0, iocfg_ff[7:4]});
  wire io_hit = io_lo_hit & (~iocfg_ff[0] | io_addr[15:8] == 8'h00);
  wire io_rd = io_lvl_ff & io_hit;
  wire [15:0] err_word = {err_ff.valid, err_ff.byte_lane[0], err_ff.row};

  // apb
  wire apb_acc = psel & penable;
  wire apb_wr = apb_acc & pwrite;
  // one decode per register, shared by the read mux, the writes and the error reply
  wire sel_config = paddr == off_config;
  wire sel_iocfg = paddr == off_iocfg;
  wire sel_status = paddr == off_status;
  wire sel_errreg = paddr == off_errreg;
  wire off_ok = sel_config | sel_iocfg | sel_status | sel_errreg;
  wire irq_clr = apb_wr & sel_status & pwdata[0];
  wire [31:0] status_word = {28'h0, ext_ref, ref_pend_ff, busy_ff, irq_ff};
  wire [31:0] apb_rd = sel_config ? config_ff :
                       sel_iocfg ? iocfg_ff :
                       sel_status ? status_word :
                       sel_errreg ? {13'h0, err_ff.byte_lane, 1'b0, err_word} : 32'h0;
  assign pready = 1'b1;
  assign pslverr = apb_acc & ~off_ok;
  assign prdata = apb_acc & ~pwrite ? apb_rd : 32'h0;

  assign transfer_acknowledge_n = ~bp_ack_ff;
  assign bp_rdata = bp_rdata_ff;
  assign lbx_ack = lbx_ack_ff;
  assign lbx_rdata = lbx_rdata_ff;
  assign io_rdata = io_rdata_ff;
  assign io_acknowledge_n = ~io_ack_ff;
  assign parity_irq = irq_ff;

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      rd_sync_ff <= 3'h7;
      wr_sync_ff <= 3'h7;
      io_sync_ff <= 3'h7;
      ext_sync_ff <= 3'h0;
      rd_lvl_ff <= 1'b0;
      wr_lvl_ff <= 1'b0;
      io_lvl_ff <= 1'b0;
      ext_lvl_ff <= 1'b0;
    end else begin
      rd_sync_ff <= {rd_sync_ff[1:0], memory_read_command_n};
      wr_sync_ff <= {wr_sync_ff[1:0], memory_write_command_n};
      io_sync_ff <= {io_sync_ff[1:0], io_read_command_n};
      ext_sync_ff <= {ext_sync_ff[1:0], ext_refresh_req};
      if (rd_sync_ff[1] == rd_sync_ff[2]) rd_lvl_ff <= ~rd_sync_ff[2];
      if (wr_sync_ff[1] == wr_sync_ff[2]) wr_lvl_ff <= ~wr_sync_ff[2];
      if (io_sync_ff[1] == io_sync_ff[2]) io_lvl_ff <= ~io_sync_ff[2];
      if (ext_sync_ff[1] == ext_sync_ff[2]) ext_lvl_ff <= ext_sync_ff[2];
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      config_ff <= config_rst;
      iocfg_ff <= iocfg_rst;
    end else if (apb_wr) begin
      if (sel_config) config_ff <= {18'h0, pwdata[13:0]};
      if (sel_iocfg) iocfg_ff <= {24'h0, pwdata[7:4], 2'b00, pwdata[1:0]};
    end
  end

  // refresh timer and pending flag; a new request beats the grant clear
  // the timer runs in both modes; external mode only ignores its tick
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      ref_timer_ff <= '0;
      ref_pend_ff <= 1'b0;
    end else begin
      ref_timer_ff <= ref_tick ? '0 : ref_timer_ff + 1'b1;
      if (ref_event) ref_pend_ff <= 1'b1;
      else if (grant_ref) ref_pend_ff <= 1'b0;
    end
  end

  // array cycle sequencer
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      busy_ff <= 1'b0;
      src_ff <= src_none;
      cnt_ff <= '0;
      cyc_wr_ff <= 1'b0;
      cyc_word_ff <= '0;
      cyc_lanes_ff <= 2'b00;
      cyc_swap_ff <= 1'b0;
      cyc_wdata_ff <= 16'h0000;
      ref_row_ff <= '0;
    end else if (grant_any) begin
      busy_ff <= 1'b1;
      cnt_ff <= cnt_w'(1);
      src_ff <= grant_ref ? src_ref : (grant_lbx ? src_lbx : src_bp);
      cyc_wr_ff <= nxt_wr;
      cyc_word_ff <= nxt_word;
      cyc_lanes_ff <= nxt_lanes;
      cyc_swap_ff <= grant_bp & bp_byte & bp_odd;
      cyc_wdata_ff <= nxt_wdata;
      if (grant_ref) ref_row_ff <= ref_row_ff + 1'b1;
    end else if (at_end) begin
      busy_ff <= 1'b0;
      src_ff <= src_none;
      cnt_ff <= '0;
    end else if (busy_ff) begin
      cnt_ff <= cnt_ff + 1'b1;
    end
  end

  // write lands at the acknowledge point, once address and data have settled
  always_ff @(posedge mclk) begin
    if (at_ack && cyc_wr_ff) begin
      mem_ff[cyc_word_ff] <= merged;
      par_ff[cyc_word_ff] <= gen_par;
    end
  end

  // acknowledges and read data
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      bp_ack_ff <= 1'b0;
      bp_done_ff <= 1'b0;
      lbx_ack_ff <= 1'b0;
      bp_rdata_ff <= 16'h0000;
      lbx_rdata_ff <= 16'h0000;
    end else begin
      lbx_ack_ff <= at_ack && src_ff == src_lbx;
      if (at_ack && src_ff == src_lbx) lbx_rdata_ff <= rd_word;
      if (at_ack && src_ff == src_bp && bp_cmd_on) begin
        bp_ack_ff <= 1'b1;
        bp_done_ff <= 1'b1;
        bp_rdata_ff <= rd_swap;
      end else if (!bp_cmd_on) begin
        bp_ack_ff <= 1'b0;
        bp_done_ff <= 1'b0;
      end
    end
  end

  // error register and interrupt
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      err_ff <= '0;
      irq_ff <= 1'b0;
      io_ack_ff <= 1'b0;
      io_rdata_ff <= 16'h0000;
    end else begin
      if (par_err) begin
        err_ff.valid <= 1'b1;
        err_ff.row <= cyc_word_ff[row_w-1:0];
        err_ff.byte_lane <= chk_mism;
      end
      // set wins over a clear in the same cycle so no error goes unsignalled
      if (par_irq_set) irq_ff <= 1'b1;
      else if (irq_clr) irq_ff <= 1'b0;
      // io acknowledge follows the synced level, so it lifts some edges after release
      io_ack_ff <= io_rd;
      if (io_rd) io_rdata_ff <= err_word;
    end
  end
endmodule // dram_board_ctrl
`default_nettype wire

// File: hdl/dram_board_pkg.sv
// Purpose: shared constants and carriers for the dual-port parity memory controller
// Assumes: 25 MHz mclk, APB register access
// Notes: times kept in ns, cycle counts derived from them
package dram_board_pkg;
  localparam int unsigned clk_period_ns = 40;
  // least times round up, longest round down, never below one cycle
  localparam int unsigned wr_ack_ns = 50;
  localparam int unsigned rd_ack_fast_ns = 105;
  localparam int unsigned rd_ack_slow_ns = 225;
  localparam int unsigned cycle_max_ns = 300;
  localparam int unsigned refresh_max_ns = 350;
  localparam int unsigned refresh_period_ns = 14000;
  localparam int unsigned wr_ack_cyc = (wr_ack_ns + clk_period_ns - 1) / clk_period_ns;
  localparam int unsigned rd_fast_cyc = (rd_ack_fast_ns + clk_period_ns - 1) / clk_period_ns;
  localparam int unsigned rd_slow_cyc = rd_ack_slow_ns / clk_period_ns;
  localparam int unsigned cycle_cyc = cycle_max_ns / clk_period_ns;
  localparam int unsigned refresh_cyc = refresh_max_ns / clk_period_ns;
  localparam int unsigned refresh_period_cyc = refresh_period_ns / clk_period_ns;
  localparam int unsigned lbx_zero_wait_cyc = 1;
  localparam int unsigned lbx_one_wait_cyc = 2;
  localparam int unsigned cnt_w = 4;
  localparam int unsigned ref_cnt_w = 9;

  localparam int unsigned addr_w = 24;
  localparam int unsigned word_addr_w = 15;
  localparam int unsigned row_w = 14;
  localparam logic [7:0] lockout_seg = 8'h0F;
  localparam logic [7:0] cap_segs = 8'h01;

  // apb register byte offsets
  localparam logic [11:0] off_config = 12'h000;
  localparam logic [11:0] off_iocfg = 12'h004;
  localparam logic [11:0] off_status = 12'h008;
  localparam logic [11:0] off_errreg = 12'h00C;

  // config field positions
  localparam int unsigned cfg_base_lsb = 0;
  localparam int unsigned cfg_lockout = 8;
  localparam int unsigned cfg_par_int_en = 9;
  localparam int unsigned cfg_par_dis = 10;
  localparam int unsigned cfg_rd_slow = 11;
  localparam int unsigned cfg_ext_refresh = 12;
  localparam int unsigned cfg_lbx_fast = 13;
  localparam logic [31:0] config_rst = 32'h0000_0000;
  // iocfg: bit0 16-bit decode, bit1 window 40h, bits 7:4 low nibble
  localparam logic [31:0] iocfg_rst = 32'h0000_0000;
  localparam logic [7:0] io_win_lo = 8'h00;
  localparam logic [7:0] io_win_hi = 8'h40;

  typedef struct packed {
    logic req;
    logic wr;
    logic [addr_w-1:0] addr;
    logic [1:0] be;
    logic [15:0] wdata;
  } mem_req_t;

  typedef struct packed {
    logic valid;
    logic [row_w-1:0] row;
    logic [1:0] byte_lane;
  } err_reg_t;

  typedef enum logic [1:0] {src_none, src_bp, src_lbx, src_ref} src_t;
endpackage

// File: hdl/parity_word.sv
// Purpose: per-byte parity generation and compare
// Assumes: even parity per byte lane
// Notes: purely combinational
`timescale 1ns/10ps
`default_nettype none
module parity_word (
  input wire logic [15:0] data,
  input wire logic [1:0] stored,
  input wire logic [1:0] lanes,
  output logic [1:0] gen,
  output logic [1:0] mismatch
);
  assign gen = {^data[15:8], ^data[7:0]};
  assign mismatch = (gen ^ stored) & lanes;
endmodule // parity_word
`default_nettype wire

// File: testbench/dram_board_monitor.sv
// Purpose: port checks for the dual-port memory controller
// Assumes: 25 MHz mclk, async active-low reset
// Notes: pin paths carry three sync stages, so early bounds are loose
`timescale 1ns/10ps
`default_nettype none
module dram_board_monitor (
  input wire logic mclk,
  input wire logic arst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic memory_read_command_n,
  input wire logic memory_write_command_n,
  input wire logic io_read_command_n,
  input wire logic transfer_acknowledge_n,
  input wire logic io_acknowledge_n,
  input wire logic parity_irq,
  input wire dram_board_pkg::mem_req_t lbx_req,
  input wire logic lbx_ack
);
  import dram_board_pkg::*;
  default clocking @(posedge mclk); endclocking
  default disable iff (!arst_n);
  wr_ack_early_a: assert property ($fell(memory_write_command_n) |-> transfer_acknowledge_n[*4])
    else $error("write acknowledge too early");
  rd_ack_early_a: assert property ($fell(memory_read_command_n) |-> transfer_acknowledge_n[*5])
    else $error("read acknowledge too early");
  ack_release_a: assert property ((memory_read_command_n && memory_write_command_n)[*6]
    |-> transfer_acknowledge_n) else $error("acknowledge held after release");
  ack_cause_a: assert property ($fell(transfer_acknowledge_n)
    |-> (!memory_read_command_n || !memory_write_command_n)) else $error("acknowledge without command");
  lbx_pulse_a: assert property (lbx_ack |=> !lbx_ack)
    else $error("local acknowledge longer than one cycle");
  lbx_early_a: assert property ($rose(lbx_req.req) |-> (!lbx_ack)[*2])
    else $error("local acknowledge too early");
  lbx_cause_a: assert property (lbx_ack |-> lbx_req.req)
    else $error("local acknowledge without request");
  io_release_a: assert property (io_read_command_n[*6] |-> io_acknowledge_n)
    else $error("io acknowledge without io read");
  irq_hold_a: assert property (parity_irq && !(psel && penable && pwrite && paddr == off_status
    && pwdata[0]) |=> parity_irq) else $error("interrupt dropped without clear");
  prdata_idle_a: assert property (!(psel && penable && !pwrite) |-> prdata == 32'h0000_0000)
    else $error("read data outside read access");
endmodule // dram_board_monitor
bind dram_board_ctrl dram_board_monitor u_dram_board_monitor (.mclk, .arst_n, .psel, .penable,
  .pwrite, .paddr, .pwdata, .prdata, .memory_read_command_n, .memory_write_command_n,
  .io_read_command_n, .transfer_acknowledge_n, .io_acknowledge_n, .parity_irq, .lbx_req,
  .lbx_ack);
`default_nettype wire

// File: testbench/bp_host_model.sv
// Purpose: backplane master and refresh source facing the controller
// Assumes: commands are levels held until acknowledge
// Notes: released lines show the inverse so stale values never match
`timescale 1ns/10ps
`default_nettype none
module bp_host_model (
  input wire logic mclk,
  input wire logic transfer_acknowledge_n,
  input wire logic io_acknowledge_n,
  input wire logic [15:0] bp_rdata,
  input wire logic [15:0] io_rdata,
  output logic [23:0] bp_addr,
  output logic [15:0] bp_wdata,
  output logic bp_byte_wide_n,
  output logic memory_read_command_n,
  output logic memory_write_command_n,
  output logic io_read_command_n,
  output logic [15:0] io_addr,
  output logic ext_refresh_req
);
  initial begin
    {memory_read_command_n, memory_write_command_n, io_read_command_n} = 3'h7;
    {bp_addr, bp_wdata, io_addr, bp_byte_wide_n, ext_refresh_req} = '0;
  end
  // k: 0 read, 1 write, 2 io read; n stops at 40 when nobody answers
  task automatic xfer(input int k, input logic bw_n, input logic [23:0] a,
      input logic [15:0] d, output logic [15:0] q, output int n);
    @(posedge mclk);
    bp_addr <= a;
    bp_wdata <= d;
    io_addr <= a[15:0];
    bp_byte_wide_n <= bw_n;
    memory_read_command_n <= (k != 0);
    memory_write_command_n <= (k != 1);
    io_read_command_n <= (k != 2);
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (((k == 2) ? io_acknowledge_n : transfer_acknowledge_n) !== 1'b0 && n < 40);
    q = (k == 2) ? io_rdata : bp_rdata;
    {memory_read_command_n, memory_write_command_n, io_read_command_n} <= 3'h7;
    bp_addr <= ~a;
    bp_wdata <= ~d;
    io_addr <= ~a[15:0];
    repeat (8) @(posedge mclk);
  endtask
  task automatic refresh_pulse();
    @(posedge mclk);
    ext_refresh_req <= 1'b1;
    repeat (6) @(posedge mclk);
    ext_refresh_req <= 1'b0;
  endtask
endmodule // bp_host_model
`default_nettype wire

// File: testbench/test_dual_port_parity_dram_board.sv
// Purpose: self-checking bench for the dual-port memory controller
// Assumes: APB master here, backplane master in the host model
// Notes: external refresh mode keeps latency counts repeatable
`timescale 1ns/10ps
`default_nettype none
module test_dual_port_parity_dram_board;
  import dram_board_pkg::*;
  logic mclk, arst_n, psel, penable, pwrite, pready, pslverr, bp_byte_high_en_n;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [23:0] bp_addr;
  logic [15:0] bp_wdata, bp_rdata, io_rdata, io_addr, lbx_rdata;
  logic bp_byte_wide_n, memory_read_command_n, memory_write_command_n, io_read_command_n;
  logic transfer_acknowledge_n, io_acknowledge_n, parity_irq, lbx_ack, ext_refresh_req;
  mem_req_t lbx_req;
  int error_cnt, tests_run;
  logic [23:0] miss [3] = '{24'h130000, 24'h110000, 24'h920020};
  dram_board_ctrl u_dram_board_ctrl (.mclk, .arst_n, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .bp_addr, .bp_wdata, .bp_byte_high_en_n,
    .bp_byte_wide_n, .memory_read_command_n, .memory_write_command_n, .io_read_command_n,
    .io_addr, .bp_rdata, .io_rdata, .transfer_acknowledge_n, .io_acknowledge_n,
    .parity_irq, .lbx_req, .lbx_ack, .lbx_rdata, .ext_refresh_req);
  bp_host_model u_bp_host_model (.mclk, .transfer_acknowledge_n, .io_acknowledge_n,
    .bp_rdata, .io_rdata, .bp_addr, .bp_wdata, .bp_byte_wide_n, .memory_read_command_n,
    .memory_write_command_n, .io_read_command_n, .io_addr, .ext_refresh_req);
  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end
  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic chk_val(input logic [31:0] got, input logic [31:0] exp, input string m);
    tests_run++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH %0t %s got %h expected %h", $time, m, got, exp);
    end
  endtask
  task automatic chk_flag(input logic got, input logic exp, input string m);
    chk_val({31'h0, got}, {31'h0, exp}, m);
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd,
      output logic [31:0] q, output logic e);
    @(posedge mclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge mclk);
    penable <= 1'b1;
    do begin
      @(posedge mclk);
    end while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic cfg(input logic [11:0] a, input logic [31:0] v);
    logic [31:0] q;
    logic e;
    apb(1'b1, a, v, q, e);
  endtask
  task automatic lbx(input logic wr, input logic [23:0] a, input logic [15:0] d,
      output logic [15:0] q, output int n);
    @(posedge mclk);
    lbx_req <= '{req: 1'b1, wr: wr, addr: a, be: 2'h3, wdata: d};
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (lbx_ack !== 1'b1 && n < 40);
    q = lbx_rdata;
    lbx_req <= '{req: 1'b0, wr: ~wr, addr: ~a, be: 2'h0, wdata: ~d};
    repeat (2) @(posedge mclk);
  endtask
  task automatic io_case(input logic [31:0] c, input logic [15:0] a, input logic hit);
    logic [15:0] q;
    int n;
    cfg(off_iocfg, c);
    u_bp_host_model.xfer(2, 1'b1, {8'h00, a}, 16'h0000, q, n);
    chk_flag(n < 40, hit, "io decode");
    if (hit) chk_val(32'(q), 32'h0000_0000, "io error read");
  endtask
  initial begin
    repeat (20000) @(posedge mclk);
    error_cnt++;
    $display("MISMATCH %0t watchdog expired", $time);
    end_sim();
  end
  initial begin
    logic [31:0] q;
    logic e;
    logic [15:0] d;
    int n, na, nb, nc;
    {psel, penable, pwrite, paddr, pwdata, bp_byte_high_en_n} = '0;
    lbx_req = '0;
    error_cnt = 0;
    tests_run = 0;
    arst_n = 1'b0;
    repeat (6) @(posedge mclk);
    arst_n <= 1'b1;
    apb(1'b0, off_config, 32'h0, q, e); chk_val(q, config_rst, "config reset");
    apb(1'b0, off_errreg, 32'h0, q, e); chk_val(q, 32'h0, "error reg reset");
    apb(1'b0, 12'h010, 32'h0, q, e); chk_flag(e, 1'b1, "unmapped offset");
    $display("reset test done");
    cfg(off_config, 32'h0000_1012);
    lbx(1'b1, 24'h120020, 16'h1234, d, n); chk_flag(n < 40, 1'b1, "local write");
    u_bp_host_model.xfer(0, 1'b1, 24'h120020, 16'h0, d, n);
    chk_val(32'(d), 32'h1234, "same map both ports");
    foreach (miss[i]) begin
      u_bp_host_model.xfer(0, 1'b1, miss[i], 16'h0, d, n);
      chk_flag(n < 40, 1'b0, "outside board answered");
    end
    u_bp_host_model.xfer(1, 1'b0, 24'h120021, 16'hABAB, d, n);
    lbx(1'b0, 24'h120020, 16'h0, d, n); chk_val(32'(d), 32'hAB34, "odd byte write");
    u_bp_host_model.xfer(0, 1'b0, 24'h120021, 16'h0, d, n);
    chk_val(32'(d), 32'hABAB, "odd byte swap");
    $display("map test done");
    u_bp_host_model.xfer(1, 1'b1, 24'h120030, 16'h0F0F, d, na);
    u_bp_host_model.xfer(0, 1'b1, 24'h120030, 16'h0, d, nb);
    chk_val(32'(nb - na), 32'h1, "fast read vs write");
    cfg(off_config, 32'h0000_1812);
    u_bp_host_model.xfer(0, 1'b1, 24'h120030, 16'h0, d, nc);
    chk_val(32'(nc - nb), 32'h2, "slow read delay");
    chk_val(32'(d), 32'h0F0F, "slow read data");
    lbx(1'b0, 24'h120030, 16'h0, d, na);
    cfg(off_config, 32'h0000_3012);
    lbx(1'b0, 24'h120030, 16'h0, d, nb);
    chk_val(32'(nb - na), 32'h1, "local wait state");
    $display("timing test done");
    cfg(off_config, 32'h0000_110F);
    lbx(1'b1, 24'h0F0100, 16'h0, d, n); chk_flag(n < 40, 1'b0, "locked segment");
    cfg(off_config, 32'h0000_100F);
    lbx(1'b1, 24'h0F0100, 16'h0, d, n); chk_flag(n < 40, 1'b1, "unlocked segment");
    cfg(off_config, 32'h0000_1612);
    u_bp_host_model.refresh_pulse();
    lbx(1'b0, 24'h120020, 16'h0, d, n); chk_val(32'(d), 32'hAB34, "read after refresh");
    chk_flag(n > 3, 1'b1, "held off by refresh");
    apb(1'b0, off_errreg, 32'h0, q, e); chk_val(q, 32'h0, "no error latched");
    apb(1'b0, off_status, 32'h0, q, e); chk_val({28'h0, q[3], 3'h0}, 32'h8, "status");
    chk_flag(parity_irq, 1'b0, "no interrupt");
    $display("option test done");
    io_case(32'h0000_0052, 16'h0145, 1'b1);
    io_case(32'h0000_0052, 16'h0046, 1'b0);
    io_case(32'h0000_0053, 16'h0145, 1'b0);
    io_case(32'h0000_0053, 16'h0045, 1'b1);
    io_case(32'h0000_0050, 16'h0005, 1'b1);
    $display("io test done");
    end_sim();
  end
endmodule // test_dual_port_parity_dram_board
`default_nettype wire
